// file: rtl/prbs_bist_gen_checker.sv
`timescale 1ns/10ps
`default_nettype none
module prbs_bist_gen_checker #(
   parameter int PKT_COUNT_WIDTH = 16
) (
   // Clock and reset
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   // AXI4-Lite write address and data
   input  wire logic [prbs_bist_pkg::ADDR_WIDTH-1:0] s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   // AXI4-Lite read
   input  wire logic [prbs_bist_pkg::ADDR_WIDTH-1:0] s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   // Generator output stream
   output prbs_bist_pkg::tx_symbol_t      tx_symbol,
   // Checker input
   input  wire prbs_bist_pkg::rx_byte_t   rx_byte,
   input  wire logic                      rx_packet_done
);

   initial begin
      if (PKT_COUNT_WIDTH < 2) $error("PKT_COUNT_WIDTH too small");
   end

   // ==========================================================================
   // Register slave
   // ==========================================================================
   logic        aw_held;
   logic        w_held;
   logic [7:0]  aw_index;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic [7:0]  next_aw_index;
   logic [31:0] next_w_data;
   logic [3:0]  next_w_strb;
   logic        next_aw_held;
   logic        next_w_held;
   logic        next_bvalid;
   logic [1:0]  next_bresp;
   logic        next_rvalid;
   logic [1:0]  next_rresp;
   logic [31:0] next_rdata;
   logic [15:0] packet_length;
   logic [7:0]  gap_units;
   logic        gen_enable;
   logic        saturate;
   logic [15:0] next_packet_length;
   logic [7:0]  next_gap_units;
   logic        next_gen_enable;
   logic        next_saturate;
   logic        do_write;
   logic        lock_pulse;
   logic        clear_pulse;
   logic        byte_ovf;
   logic        pkt_ovf;
   logic [7:0]  err_locked;
   logic [15:0] byte_locked;
   logic [7:0]  r_index;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_write      = aw_held && w_held && !s_axi_bvalid;
   assign r_index       = s_axi_araddr[prbs_bist_pkg::ADDR_WIDTH-1:2];

   always_comb begin
      next_aw_held       = aw_held;
      next_w_held        = w_held;
      next_aw_index      = aw_index;
      next_w_data        = w_data;
      next_w_strb        = w_strb;
      next_bvalid        = s_axi_bvalid;
      next_bresp         = s_axi_bresp;
      next_packet_length = packet_length;
      next_gap_units     = gap_units;
      next_gen_enable    = gen_enable;
      next_saturate      = saturate;
      lock_pulse         = 1'b0;
      clear_pulse        = 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held  = 1'b1;
         next_aw_index = s_axi_awaddr[prbs_bist_pkg::ADDR_WIDTH-1:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = prbs_bist_pkg::RESP_OKAY;
         case (aw_index)
            prbs_bist_pkg::IDX_CHECKER_STATUS: begin
               if (w_strb[0]) begin
                  lock_pulse  = w_data[prbs_bist_pkg::LOCK_BIT]
                              | w_data[prbs_bist_pkg::LOCK_CLEAR_BIT];
                  clear_pulse = w_data[prbs_bist_pkg::LOCK_CLEAR_BIT];
               end
            end
            prbs_bist_pkg::IDX_PACKET_LENGTH: begin
               if (w_strb[0]) next_packet_length[7:0] = w_data[7:0];
               if (w_strb[1]) next_packet_length[15:8] = w_data[15:8];
            end
            prbs_bist_pkg::IDX_GAP_LENGTH: begin
               if (w_strb[0]) next_gap_units = w_data[7:0];
            end
            prbs_bist_pkg::IDX_CONTROL: begin
               if (w_strb[0]) begin
                  next_gen_enable = w_data[prbs_bist_pkg::CTRL_GEN_EN_BIT];
                  next_saturate   = w_data[prbs_bist_pkg::CTRL_SAT_BIT];
               end
            end
            prbs_bist_pkg::IDX_BYTE_COUNT: begin
            end
            default: begin
               next_bresp = prbs_bist_pkg::RESP_SLVERR;
            end
         endcase
      end
   end

   always_comb begin
      next_rvalid = s_axi_rvalid;
      next_rresp  = s_axi_rresp;
      next_rdata  = s_axi_rdata;
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp  = prbs_bist_pkg::RESP_OKAY;
         next_rdata  = 32'h0000_0000;
         case (r_index)
            prbs_bist_pkg::IDX_BYTE_COUNT: begin
               next_rdata[15:0] = byte_locked;
            end
            prbs_bist_pkg::IDX_CHECKER_STATUS: begin
               next_rdata[prbs_bist_pkg::PKT_OVF_BIT]  = pkt_ovf;
               next_rdata[prbs_bist_pkg::BYTE_OVF_BIT] = byte_ovf;
               next_rdata[7:0] = err_locked;
            end
            prbs_bist_pkg::IDX_PACKET_LENGTH: begin
               next_rdata[15:0] = packet_length;
            end
            prbs_bist_pkg::IDX_GAP_LENGTH: begin
               next_rdata[7:0] = gap_units;
            end
            prbs_bist_pkg::IDX_CONTROL: begin
               next_rdata[prbs_bist_pkg::CTRL_GEN_EN_BIT] = gen_enable;
               next_rdata[prbs_bist_pkg::CTRL_SAT_BIT]    = saturate;
            end
            default: begin
               next_rresp = prbs_bist_pkg::RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_index      <= 8'h00;
         w_data        <= 32'h0000_0000;
         w_strb        <= 4'h0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= prbs_bist_pkg::RESP_OKAY;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= prbs_bist_pkg::RESP_OKAY;
         s_axi_rdata   <= 32'h0000_0000;
         packet_length <= prbs_bist_pkg::PACKET_LENGTH_RESET;
         gap_units     <= prbs_bist_pkg::GAP_UNITS_RESET;
         gen_enable    <= 1'b0;
         saturate      <= 1'b1;
      end else begin
         aw_held       <= next_aw_held;
         w_held        <= next_w_held;
         aw_index      <= next_aw_index;
         w_data        <= next_w_data;
         w_strb        <= next_w_strb;
         s_axi_bvalid  <= next_bvalid;
         s_axi_bresp   <= next_bresp;
         s_axi_rvalid  <= next_rvalid;
         s_axi_rresp   <= next_rresp;
         s_axi_rdata   <= next_rdata;
         packet_length <= next_packet_length;
         gap_units     <= next_gap_units;
         gen_enable    <= next_gen_enable;
         saturate      <= next_saturate;
      end
   end

   // ==========================================================================
   // Checker counters
   // ==========================================================================
   // The saturate control bit is the inverse of the counter mode setting:
   // mode zero (bit set) stops the counts at their maximum.
   prbs_counter #(.WIDTH(8)) u_err_count (
      .aclk         (aclk),
      .aresetn      (aresetn),
      .incr         (rx_byte.valid && rx_byte.error),
      .saturate     (saturate),
      .lock         (lock_pulse),
      .clear        (clear_pulse),
      .overflow     (),
      .locked_value (err_locked)
   );

   prbs_counter #(.WIDTH(16)) u_byte_count (
      .aclk         (aclk),
      .aresetn      (aresetn),
      .incr         (rx_byte.valid),
      .saturate     (saturate),
      .lock         (lock_pulse),
      .clear        (clear_pulse),
      .overflow     (byte_ovf),
      .locked_value (byte_locked)
   );

   prbs_counter #(.WIDTH(PKT_COUNT_WIDTH)) u_pkt_count (
      .aclk         (aclk),
      .aresetn      (aresetn),
      .incr         (rx_packet_done),
      .saturate     (saturate),
      .lock         (lock_pulse),
      .clear        (clear_pulse),
      .overflow     (pkt_ovf),
      .locked_value ()
   );

   // ==========================================================================
   // Packet generator
   // ==========================================================================
   prbs_bist_pkg::gen_state_t state;
   prbs_bist_pkg::gen_state_t next_state;
   logic [17:0]               count;
   logic [17:0]               next_count;
   logic [14:0]               lfsr;
   logic [14:0]               next_lfsr;
   prbs_bist_pkg::tx_symbol_t next_tx_symbol;
   logic [7:0]                prbs_byte;
   logic                      gen_go;

   assign gen_go = gen_enable && (packet_length != 16'h0000);

   // Eight steps of x^15 + x^14 + 1 per byte.
   always_comb begin
      next_lfsr = lfsr;
      for (int i = 0; i < 8; i++) begin
         prbs_byte[i] = next_lfsr[14];
         next_lfsr    = {next_lfsr[13:0], next_lfsr[14] ^ next_lfsr[13]};
      end
      if (state != prbs_bist_pkg::GEN_PAYLOAD) begin
         next_lfsr = lfsr;
      end
   end

   always_comb begin
      next_state     = state;
      next_count     = count;
      next_tx_symbol = '0;
      case (state)
         prbs_bist_pkg::GEN_IDLE: begin
            if (gen_enable && packet_length != 16'h0000) begin
               next_state = prbs_bist_pkg::GEN_PREAMBLE;
               next_count = 18'h00000;
            end
         end
         prbs_bist_pkg::GEN_PREAMBLE: begin
            next_tx_symbol.valid = 1'b1;
            next_count           = count + 18'h00001;
            if (count < 18'(prbs_bist_pkg::PREAMBLE_NIBBLES)) begin
               next_tx_symbol.is_nibble = 1'b1;
               next_tx_symbol.data      = {4'h0, prbs_bist_pkg::PREAMBLE_NIBBLE};
            end else begin
               next_tx_symbol.data = prbs_bist_pkg::SFD_BYTE;
               next_state          = prbs_bist_pkg::GEN_PAYLOAD;
               next_count          = 18'h00000;
            end
         end
         prbs_bist_pkg::GEN_PAYLOAD: begin
            next_tx_symbol.valid = 1'b1;
            next_tx_symbol.data  = prbs_byte;
            next_count           = count + 18'h00001;
            if (count + 18'h00001 >= {2'b00, packet_length}) begin
               next_count = 18'h00000;
               if (gap_units != 8'h00) begin
                  next_state = prbs_bist_pkg::GEN_GAP;
               end else if (gen_go) begin
                  next_state = prbs_bist_pkg::GEN_PREAMBLE;
               end else begin
                  next_state = prbs_bist_pkg::GEN_IDLE;
               end
            end
         end
         prbs_bist_pkg::GEN_GAP: begin
            next_count = count + 18'h00001;
            if (count + 18'h00001 >= 18'(gap_units) * 18'(prbs_bist_pkg::GAP_BYTES_PER_UNIT)) begin
               // The next preamble follows the gap directly, so the gap is exact.
               next_state = gen_go ? prbs_bist_pkg::GEN_PREAMBLE : prbs_bist_pkg::GEN_IDLE;
               next_count = 18'h00000;
            end
         end
         default: begin
            next_state = prbs_bist_pkg::GEN_IDLE;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state     <= prbs_bist_pkg::GEN_IDLE;
         count     <= 18'h00000;
         lfsr      <= 15'h7FFF;
         tx_symbol <= '0;
      end else begin
         state     <= next_state;
         count     <= next_count;
         lfsr      <= next_lfsr;
         tx_symbol <= next_tx_symbol;
      end
   end

   // ==========================================================================
   // Checks
   // ==========================================================================
   sfd_follows_a : assert property (@(posedge aclk) disable iff (!aresetn)
      (state == prbs_bist_pkg::GEN_PREAMBLE && count == 18'(prbs_bist_pkg::PREAMBLE_NIBBLES))
      |=> tx_symbol.valid && !tx_symbol.is_nibble
          && tx_symbol.data == prbs_bist_pkg::SFD_BYTE)
      else $error("delimiter did not follow preamble");
   payload_length_a : assert property (@(posedge aclk) disable iff (!aresetn)
      (state == prbs_bist_pkg::GEN_PAYLOAD) |-> count < {2'b00, packet_length})
      else $error("payload ran past packet length");
   gap_length_a : assert property (@(posedge aclk) disable iff (!aresetn)
      (state == prbs_bist_pkg::GEN_GAP)
      |-> count < 18'(gap_units) * 18'(prbs_bist_pkg::GAP_BYTES_PER_UNIT))
      else $error("gap ran past programmed length");
   lock_clear_a : assert property (@(posedge aclk) disable iff (!aresetn)
      (clear_pulse && !rx_byte.valid && !rx_packet_done)
      |=> !byte_ovf && !pkt_ovf && byte_locked == $past(u_byte_count.count))
      else $error("lock and clear did not clear");
   status_read_a : assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && r_index == prbs_bist_pkg::IDX_CHECKER_STATUS)
      |=> s_axi_rvalid && s_axi_rdata[31:11] == 21'h0 && s_axi_rdata[8] == 1'b0
          && s_axi_rdata[9] == $past(byte_ovf) && s_axi_rdata[10] == $past(pkt_ovf))
      else $error("status read wrong");
   err_reported_a : assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && r_index == prbs_bist_pkg::IDX_CHECKER_STATUS)
      |=> s_axi_rdata[7:0] == $past(err_locked))
      else $error("error count read wrong");
   lock_write_a : assert property (@(posedge aclk) disable iff (!aresetn)
      (do_write && aw_index == prbs_bist_pkg::IDX_CHECKER_STATUS && w_strb[0] && w_data[0])
      |-> lock_pulse)
      else $error("lock write ignored");

   pkt_sent_c : cover property (@(posedge aclk) disable iff (!aresetn)
      state == prbs_bist_pkg::GEN_PAYLOAD ##1 state == prbs_bist_pkg::GEN_GAP);
   lock_seen_c : cover property (@(posedge aclk) disable iff (!aresetn) lock_pulse);
   clear_seen_c : cover property (@(posedge aclk) disable iff (!aresetn) clear_pulse && byte_ovf);

endmodule : prbs_bist_gen_checker
`default_nettype wire

// file: common/prbs_bist_pkg.sv
// How it works
// - The packet-count overflow flag in bit 10 of the checker status register sets when the packet counter overflows.
// - The byte-count overflow flag in bit 9 of the checker status register sets when the byte counter overflows.
// - Both overflow flags clear when software writes bit 1 of the checker status register; a flag whose counter overflows in that same cycle stays set.
// - An 8-bit read-only count of received error bytes sits in bits 7 to 0 of the checker status register.
// - With counter_saturate_select at zero the error-byte count stops at 0xFF instead of wrapping.
// - Writing bit 0 of the checker status register locks the checker counters for software reads.
// - Writing bit 1 of the checker status register locks and clears the checker counters.
// - Every generated packet is as many bytes long as the 16-bit packet length field, reset 1500.
// - Each packet is preceded by thirteen nibbles of 5 and then the delimiter byte D5.
// - Successive packets are separated by four bytes per unit of the 8-bit gap field, reset 0x7D.
// - A 16-bit received-byte count is kept, locked by the same writes, saturating at 0xFFFF in mode zero.
`default_nettype none
package prbs_bist_pkg;

   // =========================================================================
   // Register map
   // =========================================================================
   // Printed offsets are not all multiples of four, so they are word indices.
   localparam logic [7:0]  IDX_BYTE_COUNT     = 8'h71;
   localparam logic [7:0]  IDX_CHECKER_STATUS = 8'h72;
   localparam logic [7:0]  IDX_PACKET_LENGTH  = 8'h7B;
   localparam logic [7:0]  IDX_GAP_LENGTH     = 8'h7C;
   localparam logic [7:0]  IDX_CONTROL        = 8'h80;
   localparam int          ADDR_WIDTH         = 10;

   localparam int          LOCK_BIT           = 0;
   localparam int          LOCK_CLEAR_BIT     = 1;
   localparam int          BYTE_OVF_BIT       = 9;
   localparam int          PKT_OVF_BIT        = 10;
   localparam int          CTRL_GEN_EN_BIT    = 0;
   localparam int          CTRL_SAT_BIT       = 1;

   localparam logic [15:0] PACKET_LENGTH_RESET = 16'h05DC;
   localparam logic [7:0]  GAP_UNITS_RESET     = 8'h7D;
   localparam logic [1:0]  RESP_OKAY           = 2'h0;
   localparam logic [1:0]  RESP_SLVERR         = 2'h2;

   // =========================================================================
   // Generator framing
   // =========================================================================
   localparam int          PREAMBLE_NIBBLES = 13;
   localparam logic [3:0]  PREAMBLE_NIBBLE  = 4'h5;
   localparam logic [7:0]  SFD_BYTE         = 8'hD5;
   localparam int          GAP_BYTES_PER_UNIT = 4;

   typedef enum logic [1:0] {
      GEN_IDLE     = 2'b00,
      GEN_PREAMBLE = 2'b01,
      GEN_PAYLOAD  = 2'b10,
      GEN_GAP      = 2'b11
   } gen_state_t;

   typedef struct packed {
      logic       valid;
      logic       is_nibble;
      logic [7:0] data;
   } tx_symbol_t;

   typedef struct packed {
      logic       valid;
      logic       error;
   } rx_byte_t;

endpackage : prbs_bist_pkg
`default_nettype wire

// file: rtl/prbs_counter.sv
`timescale 1ns/10ps
`default_nettype none
// Checker counter with saturate/wrap, overflow flag and lock snapshot.
module prbs_counter #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             aclk,
   input  wire logic             aresetn,
   // Control
   input  wire logic             incr,
   input  wire logic             saturate,
   input  wire logic             lock,
   input  wire logic             clear,
   // Result
   output logic                  overflow,
   output logic [WIDTH-1:0]      locked_value
);

   initial begin
      if (WIDTH < 2) $error("prbs_counter: WIDTH too small");
   end

   logic [WIDTH-1:0] count;
   logic [WIDTH-1:0] next_count;
   logic             next_overflow;
   logic [WIDTH-1:0] next_locked_value;
   logic             at_max;

   assign at_max = &count;

   always_comb begin
      next_count        = count;
      next_overflow     = overflow;
      next_locked_value = locked_value;
      if (incr) begin
         if (at_max) begin
            if (!saturate) begin
               next_count = '0;
            end
         end else begin
            next_count = count + {{(WIDTH-1){1'b0}}, 1'b1};
         end
      end
      if (lock) begin
         next_locked_value = count;
      end
      if (clear) begin
         next_count    = '0;
         next_overflow = 1'b0;
      end
      // An overflow in the same cycle as a clear still leaves the flag set.
      if (incr && at_max) begin
         next_overflow = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count        <= '0;
         overflow     <= 1'b0;
         locked_value <= '0;
      end else begin
         count        <= next_count;
         overflow     <= next_overflow;
         locked_value <= next_locked_value;
      end
   end

   saturate_holds_a : assert property (@(posedge aclk) disable iff (!aresetn)
      (saturate && at_max && incr && !clear) |=> &count)
      else $error("saturating counter moved off its maximum");
   clear_zeroes_a : assert property (@(posedge aclk) disable iff (!aresetn)
      clear |=> (count == '0) && (!overflow || ($past(incr) && $past(at_max))))
      else $error("clear left counter or overflow set");
   snapshot_stable_a : assert property (@(posedge aclk) disable iff (!aresetn)
      !lock |=> $stable(locked_value))
      else $error("locked value changed without a lock");

endmodule : prbs_counter
`default_nettype wire

// file: verif/prbs_bist_gen_checker_tb.sv
`timescale 1ns/10ps
`default_nettype none
module prbs_bist_gen_checker_tb;
   // ==========================================================================
   // Stimulus and observed signals
   // ==========================================================================
   logic                       aclk = 1'b0;
   logic                       aresetn = 1'b0;
   logic [9:0]                 awaddr = '0;
   logic [9:0]                 araddr = '0;
   logic [31:0]                wdata = '0;
   logic [3:0]                 wstrb = 4'hF;
   logic                       awvalid = 1'b0;
   logic                       wvalid = 1'b0;
   logic                       bready = 1'b0;
   logic                       arvalid = 1'b0;
   logic                       rready = 1'b0;
   logic                       awready, wready, bvalid, arready, rvalid;
   logic [1:0]                 bresp, rresp;
   logic [31:0]                rdata;
   prbs_bist_pkg::tx_symbol_t  tx_symbol;
   prbs_bist_pkg::rx_byte_t    rx_byte = '0;
   logic                       rx_packet_done = 1'b0;
   int                         miscompares = 0;
   int                         checks = 0;
   int                         n;

   always #2.5 aclk = ~aclk;

   // The packet counter is narrowed so that its overflow is reached quickly.
   prbs_bist_gen_checker #(.PKT_COUNT_WIDTH(4)) u_prbs_bist_gen_checker (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_symbol(tx_symbol),
      .rx_byte(rx_byte), .rx_packet_done(rx_packet_done)
   );

   // ==========================================================================
   // Reporting
   // ==========================================================================
   task automatic test_done();
      if (miscompares == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : test_done

   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp

   task automatic guard(input logic ok);
      if (ok !== 1'b1) begin
         miscompares++;
         $display("[ERR] wait expected 1 seen 0");
         test_done();
      end
   endtask : guard

   // ==========================================================================
   // Register bus master
   // ==========================================================================
   task automatic wr(input logic [7:0] idx, input logic [31:0] d,
                     input logic [1:0] er = prbs_bist_pkg::RESP_OKAY);
      int k;
      k = 0;
      @(posedge aclk);
      awaddr  <= {idx, 2'b00};
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge aclk);
         k++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid && k < 50);
      guard(bvalid);
      cmp("bresp", {30'h0, er}, {30'h0, bresp});
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] idx, input logic [31:0] exp,
                     input logic [1:0] er = prbs_bist_pkg::RESP_OKAY);
      int k;
      k = 0;
      @(posedge aclk);
      araddr  <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge aclk);
         k++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid && k < 50);
      guard(rvalid);
      cmp("rresp", {30'h0, er}, {30'h0, rresp});
      if (er === prbs_bist_pkg::RESP_OKAY) cmp("rdata", exp, rdata);
      rready <= 1'b0;
   endtask : rd

   // Feeds received checker bytes, one per cycle, with packet completions.
   task automatic send(input int cnt, input logic err, input int pkts);
      for (int i = 0; i < cnt; i++) begin
         @(posedge aclk);
         rx_byte        <= {1'b1, err};
         rx_packet_done <= (i < pkts);
      end
      @(posedge aclk);
      rx_byte        <= '0;
      rx_packet_done <= 1'b0;
   endtask : send

   // ==========================================================================
   // Test sequence
   // ==========================================================================
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd(prbs_bist_pkg::IDX_BYTE_COUNT, 32'h0);
      rd(prbs_bist_pkg::IDX_CHECKER_STATUS, 32'h0);
      rd(prbs_bist_pkg::IDX_PACKET_LENGTH, 32'h05DC);
      rd(prbs_bist_pkg::IDX_GAP_LENGTH, 32'h007D);
      wr(8'h10, 32'h1, prbs_bist_pkg::RESP_SLVERR);
      rd(8'h10, 32'h0, prbs_bist_pkg::RESP_SLVERR);
      send(3, 1'b1, 0);
      send(2, 1'b0, 0);
      wr(prbs_bist_pkg::IDX_CHECKER_STATUS, 32'h1);
      rd(prbs_bist_pkg::IDX_CHECKER_STATUS, 32'h3);
      rd(prbs_bist_pkg::IDX_BYTE_COUNT, 32'h5);
      send(4, 1'b1, 0);
      wr(prbs_bist_pkg::IDX_CHECKER_STATUS, 32'hFFFF_FFFC);
      rd(prbs_bist_pkg::IDX_CHECKER_STATUS, 32'h3);
      wr(prbs_bist_pkg::IDX_CHECKER_STATUS, 32'h2);
      rd(prbs_bist_pkg::IDX_CHECKER_STATUS, 32'h7);
      rd(prbs_bist_pkg::IDX_BYTE_COUNT, 32'h9);
      wr(prbs_bist_pkg::IDX_CHECKER_STATUS, 32'h1);
      rd(prbs_bist_pkg::IDX_CHECKER_STATUS, 32'h0);
      send(65536, 1'b1, 16);
      wr(prbs_bist_pkg::IDX_CHECKER_STATUS, 32'h1);
      rd(prbs_bist_pkg::IDX_CHECKER_STATUS, 32'h06FF);
      rd(prbs_bist_pkg::IDX_BYTE_COUNT, 32'hFFFF);
      wr(prbs_bist_pkg::IDX_CHECKER_STATUS, 32'h2);
      rd(prbs_bist_pkg::IDX_CHECKER_STATUS, 32'h00FF);
      // Wrap mode: 257 error bytes from zero leave the error count at one.
      wr(prbs_bist_pkg::IDX_CONTROL, 32'h0);
      send(257, 1'b1, 0);
      wr(prbs_bist_pkg::IDX_CHECKER_STATUS, 32'h1);
      rd(prbs_bist_pkg::IDX_CHECKER_STATUS, 32'h1);
      rd(prbs_bist_pkg::IDX_BYTE_COUNT, 32'h101);
      // Without the low byte lane the lock-and-clear write has no effect.
      wstrb <= 4'hE;
      wr(prbs_bist_pkg::IDX_CHECKER_STATUS, 32'h2);
      wstrb <= 4'hF;
      rd(prbs_bist_pkg::IDX_CHECKER_STATUS, 32'h1);
      // A short packet and a one-unit gap keep the generator walk brief.
      wr(prbs_bist_pkg::IDX_PACKET_LENGTH, 32'h3);
      wr(prbs_bist_pkg::IDX_GAP_LENGTH, 32'hFFFF_FF01);
      rd(prbs_bist_pkg::IDX_GAP_LENGTH, 32'h1);
      wr(prbs_bist_pkg::IDX_CONTROL, 32'h3);
      n = 0;
      while (tx_symbol.valid !== 1'b1 && n < 100) begin
         @(posedge aclk);
         n++;
      end
      guard(n < 100);
      for (int i = 0; i < 17; i++) begin
         if (i < 13) cmp("preamble", 32'h305, {22'h0, tx_symbol});
         else if (i == 13) cmp("sfd", 32'h2D5, {22'h0, tx_symbol});
         else cmp("payload", 32'h2, {30'h0, tx_symbol[9:8]});
         @(posedge aclk);
      end
      n = 0;
      while (tx_symbol.valid !== 1'b1 && n < 50) begin
         n++;
         @(posedge aclk);
      end
      cmp("gap", prbs_bist_pkg::GAP_BYTES_PER_UNIT, n);
      cmp("next preamble", 32'h305, {22'h0, tx_symbol});
      test_done();
   end
endmodule : prbs_bist_gen_checker_tb
`default_nettype wire
